// ---- core/pfc_config_regs.sv ----
// Configuration header registers 0Ch to 17h of the host-controller function.
`timescale 1ns/1ps
`default_nettype none

module pfc_config_regs (
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Configuration cycle port from the target decode.
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_ack_o,
	// Bus master side; frame start and done come from logic on this clock,
	// the grant straight from its pin.
	input wire logic frame_start_i,
	input wire logic xfer_done_i,
	input wire logic gnt_n_i,
	input wire logic line_cmd_i,
	output logic [7:0] line_transfer_size_o,
	output logic line_cmd_ok_o,
	output logic [7:0] tenure_count_o,
	output logic tenure_expired_o,
	output logic terminate_o,
	// Memory decode against the two windows; the address is sampled on the
	// same clock as the request that qualifies it.
	input wire logic mem_space_en_i,
	input wire logic mem_req_i,
	input wire logic [31:0] mem_addr_i,
	output logic host_ctrl_hit_o,
	output logic ext_hit_o
);

	// Field geometry comes from the package; the write lanes and reset slices below still fix bit positions, so resizing a window touches them too.
	// The short names keep the concatenations below on one line each.
	localparam int FW = pfc_pkg::FIELD_W;
	localparam int HW = pfc_pkg::HOST_CTRL_ADDR_W;
	localparam int EW = pfc_pkg::EXT_ADDR_W;
	localparam int HL = pfc_pkg::HOST_CTRL_ADDR_LSB;
	localparam int EL = pfc_pkg::EXT_ADDR_LSB;

	////////////////////////////////////////////////////////////////////////////
	// Stored fields. The window address fields hold only the writable upper
	// bits; everything below them is rebuilt as constant zero on every read.
	logic [FW-1:0] line_size_ff;
	logic [FW-1:0] nxt_line_size;
	logic [FW-1:0] tenure_limit_ff;
	logic [FW-1:0] nxt_tenure_limit;
	logic [HW-1:0] host_ctrl_window_addr_ff;
	logic [HW-1:0] nxt_host_ctrl_window_addr;
	logic [EW-1:0] ext_window_addr_ff;
	logic [EW-1:0] nxt_ext_window_addr;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic ack_ff;
	logic nxt_ack;
	logic host_hit_ff;
	logic nxt_host_hit;
	logic ext_hit_ff;
	logic nxt_ext_hit;

	// Grant synchroniser and filtered level.
	// Only the filtered level leaves this group; the raw stages are private.
	logic gnt_s1_ff;
	logic gnt_s2_ff;
	logic gnt_s3_ff;
	logic gnt_n_ff;
	logic nxt_gnt_n;

	// Read views of each dword.
	// They are pure wiring, so they cost no flip-flops.
	logic [31:0] dw_tenure_header;
	logic [31:0] dw_host_ctrl;
	logic [31:0] dw_ext;
	logic wr_take;
	logic rd_take;

	////////////////////////////////////////////////////////////////////////////
	// Read composition. Size, prefetch, decode type and space flag bits are
	// constant zero; in the window dwords only the address fields are storage.
	// Keeping the constant bits out of storage means no write can disturb
	// them, whatever byte enables the host presents.
	always_comb begin
		dw_tenure_header = {pfc_pkg::SELFTEST_FIELD_VAL,
			pfc_pkg::HEADER_TYPE_CODE,
			tenure_limit_ff, line_size_ff};
		dw_host_ctrl = {host_ctrl_window_addr_ff, {HL{1'b0}}};
		dw_ext = {ext_window_addr_ff, {EL{1'b0}}};
	end

	// Only configuration cycles reach these registers. The direction bit
	// qualifies the single request, so a write and a read are never taken
	// together in one cycle.
	assign wr_take = cfg_req_i && cfg_we_i;
	assign rd_take = cfg_req_i && !cfg_we_i;

	////////////////////////////////////////////////////////////////////////////
	// Register write next values. Byte lanes two and three of dword 0Ch hold
	// the read-only header byte and self-test byte, so those enables are
	// simply not looked at; the bits below each window's address field in
	// byte one are likewise dropped. A partial write leaves untouched lanes
	// as they were, so firmware may size a window one byte at a time.
	always_comb begin
		nxt_line_size = line_size_ff;
		nxt_tenure_limit = tenure_limit_ff;
		nxt_host_ctrl_window_addr = host_ctrl_window_addr_ff;
		nxt_ext_window_addr = ext_window_addr_ff;
		if (wr_take) begin
			unique case (cfg_addr_i[7:2])
				pfc_pkg::OFS_TENURE_LINE[7:2]: begin
					if (cfg_be_i[0]) begin
						nxt_line_size = cfg_wdata_i[7:0];
					end
					if (cfg_be_i[1]) begin
						nxt_tenure_limit = cfg_wdata_i[15:8];
					end
					// Lanes 2 and 3 carry no storage.
				end
				pfc_pkg::OFS_HOST_CTRL_BASE[7:2]: begin
					if (cfg_be_i[1]) begin
						nxt_host_ctrl_window_addr[4:0] = cfg_wdata_i[15:11];
					end
					if (cfg_be_i[2]) begin
						nxt_host_ctrl_window_addr[12:5] = cfg_wdata_i[23:16];
					end
					if (cfg_be_i[3]) begin
						nxt_host_ctrl_window_addr[20:13] = cfg_wdata_i[31:24];
					end
				end
				pfc_pkg::OFS_EXT_BASE[7:2]: begin
					if (cfg_be_i[1]) begin
						nxt_ext_window_addr[1:0] = cfg_wdata_i[15:14];
					end
					if (cfg_be_i[2]) begin
						nxt_ext_window_addr[9:2] = cfg_wdata_i[23:16];
					end
					if (cfg_be_i[3]) begin
						nxt_ext_window_addr[17:10] = cfg_wdata_i[31:24];
					end
				end
				default: begin
					// Other offsets belong to neighbouring logic; nothing changes.
					nxt_line_size = line_size_ff;
				end
			endcase
		end
	end

	// Field registers. Reset values come from the package, so the read view
	// after reset matches the register defaults.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			line_size_ff <= pfc_pkg::RST_TENURE_LINE[7:0];
			tenure_limit_ff <= pfc_pkg::RST_TENURE_LINE[15:8];
			host_ctrl_window_addr_ff <= pfc_pkg::RST_HOST_CTRL_BASE[31:11];
			ext_window_addr_ff <= pfc_pkg::RST_EXT_BASE[31:14];
		end else begin
			line_size_ff <= nxt_line_size;
			tenure_limit_ff <= nxt_tenure_limit;
			host_ctrl_window_addr_ff <= nxt_host_ctrl_window_addr;
			ext_window_addr_ff <= nxt_ext_window_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data and acknowledge. Every request, mapped or not, is answered one
	// cycle later so the target state machine never hangs; unmapped offsets
	// read as zero. Read data is held until the next read is taken.
	// The parent must therefore route only this slice's offsets to the port,
	// or two answers would collide on the target state machine.
	always_comb begin
		nxt_ack = cfg_req_i;
		nxt_rdata = rdata_ff;
		if (rd_take) begin
			unique case (cfg_addr_i[7:2])
				pfc_pkg::OFS_TENURE_LINE[7:2]: begin
					nxt_rdata = dw_tenure_header;
				end
				pfc_pkg::OFS_HOST_CTRL_BASE[7:2]: begin
					nxt_rdata = dw_host_ctrl;
				end
				pfc_pkg::OFS_EXT_BASE[7:2]: begin
					nxt_rdata = dw_ext;
				end
				default: begin
					nxt_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Answer registers. Acknowledge is a one-cycle pulse because each request
	// is itself a single-cycle pulse.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_ff <= 32'h0000_0000;
			ack_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			ack_ff <= nxt_ack;
		end
	end

	assign cfg_rdata_o = rdata_ff;
	assign cfg_ack_o = ack_ff;

	////////////////////////////////////////////////////////////////////////////
	// Grant pin synchroniser. The first stage feeds only the second; the
	// filtered level moves once stages two and three agree, which costs a
	// cycle of latency but rejects a single-cycle glitch.
	// Reset leaves every stage at the removed level, so a grant that is
	// already present at release counts only once it has settled.
	always_comb begin
		nxt_gnt_n = gnt_n_ff;
		if (gnt_s2_ff == gnt_s3_ff) begin
			nxt_gnt_n = gnt_s3_ff;
		end
	end

	// Synchroniser registers; the bus idles with grant removed.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gnt_s1_ff <= 1'b1;
			gnt_s2_ff <= 1'b1;
			gnt_s3_ff <= 1'b1;
			gnt_n_ff <= 1'b1;
		end else begin
			gnt_s1_ff <= gnt_n_i;
			gnt_s2_ff <= gnt_s1_ff;
			gnt_s3_ff <= gnt_s2_ff;
			gnt_n_ff <= nxt_gnt_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Tenure counter; the limit is the programmed byte. The timer sees the
	// filtered grant, so termination trails the pin by four to five cycles,
	// and firmware should leave that margin when it picks a limit.
	pfc_tenure_timer #(
		.CNT_W(FW)
	) u_tenure (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.frame_start_i(frame_start_i),
		.xfer_done_i(xfer_done_i),
		.gnt_active_i(!gnt_n_ff),
		.limit_i(tenure_limit_ff),
		.count_o(tenure_count_o),
		.expired_o(tenure_expired_o),
		.terminate_o(terminate_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// Line-sized commands are only sensible once firmware has set a size; with
	// size zero the master must fall back to plain reads and writes.
	// The size itself is passed on unchecked; a value that is not a power of
	// two is the firmware's concern, not this slice's.
	assign line_transfer_size_o = line_size_ff;
	assign line_cmd_ok_o = line_cmd_i && (line_size_ff != '0);

	////////////////////////////////////////////////////////////////////////////
	// Window decode. Hits are registered, adding one cycle, to keep the wide
	// compare off the target's critical path.
	// A window whose base is still zero decodes the bottom of memory; the
	// memory space enable keeps that harmless until firmware places it.
	always_comb begin
		nxt_host_hit = mem_req_i && mem_space_en_i &&
			(mem_addr_i[31:HL] == host_ctrl_window_addr_ff);
		nxt_ext_hit = mem_req_i && mem_space_en_i &&
			(mem_addr_i[31:EL] == ext_window_addr_ff);
	end

	// Decode registers. They clear at reset, so no stale hit is seen in the
	// first cycle after release.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			host_hit_ff <= 1'b0;
			ext_hit_ff <= 1'b0;
		end else begin
			host_hit_ff <= nxt_host_hit;
			ext_hit_ff <= nxt_ext_hit;
		end
	end

	assign host_ctrl_hit_o = host_hit_ff;
	assign ext_hit_o = ext_hit_ff;

endmodule : pfc_config_regs

`default_nettype wire

// ---- core/pfc_pkg.sv ----
// Constants shared by the configuration header register slice.
package pfc_pkg;

	// Configuration dword offsets (byte addresses) of the registers kept here.
	localparam logic [7:0] OFS_TENURE_LINE = 8'h0c;
	localparam logic [7:0] OFS_HEADER_SELFTEST = 8'h0e;
	localparam logic [7:0] OFS_HOST_CTRL_BASE = 8'h10;
	localparam logic [7:0] OFS_EXT_BASE = 8'h14;

	// Reset values.
	localparam logic [15:0] RST_TENURE_LINE = 16'h0000;
	localparam logic [15:0] RST_HEADER_SELFTEST = 16'h0080;
	localparam logic [31:0] RST_HOST_CTRL_BASE = 32'h0000_0000;
	localparam logic [31:0] RST_EXT_BASE = 32'h0000_0000;

	// Fixed read-only field values.
	localparam logic [7:0] HEADER_TYPE_CODE = 8'h80;
	localparam logic [7:0] SELFTEST_FIELD_VAL = 8'h00;

	// Field positions and widths.
	localparam int LINE_SIZE_LSB = 0;
	localparam int TENURE_LSB = 8;
	localparam int FIELD_W = 8;
	localparam int HOST_CTRL_ADDR_LSB = 11;
	localparam int HOST_CTRL_ADDR_W = 21;
	localparam int EXT_ADDR_LSB = 14;
	localparam int EXT_ADDR_W = 18;

	// Latency from a taken configuration request to its acknowledge.
	localparam int CFG_ACK_CYCLES = 1;

endpackage : pfc_pkg

// ---- core/pfc_tenure_timer.sv ----
// Bus-tenure limit counter that ends an initiator transaction after the limit.
`timescale 1ns/1ps
`default_nettype none

module pfc_tenure_timer #(
	parameter int CNT_W = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic frame_start_i,
	input wire logic xfer_done_i,
	input wire logic gnt_active_i,
	input wire logic [CNT_W-1:0] limit_i,
	output logic [CNT_W-1:0] count_o,
	output logic expired_o,
	output logic terminate_o
);

	typedef enum logic [2:0] {
		PFC_IDLE = 3'b001,
		PFC_COUNT = 3'b010,
		PFC_EXPIRED = 3'b100
	} pfc_tmr_state_t;

	pfc_tmr_state_t state_ff;
	pfc_tmr_state_t nxt_state;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic term_ff;
	logic nxt_term;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic. A new frame always restarts the count from zero, even
	// while a previous tenure is still open, so back-to-back frames are safe.
	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		nxt_term = 1'b0;
		if (frame_start_i) begin
			nxt_state = PFC_COUNT;
			nxt_count = '0;
		end else begin
			unique case (state_ff)
				PFC_IDLE: begin
					nxt_count = count_ff;
				end
				PFC_COUNT: begin
					if (xfer_done_i) begin
						nxt_state = PFC_IDLE;
					end else if (count_ff >= limit_i) begin
						nxt_state = PFC_EXPIRED;
					end else begin
						nxt_count = count_ff + 1'b1;
					end
				end
				PFC_EXPIRED: begin
					// Ending waits for grant removal; a limit of zero expires at once.
					if (xfer_done_i) begin
						nxt_state = PFC_IDLE;
					end else if (!gnt_active_i) begin
						nxt_term = 1'b1;
						nxt_state = PFC_IDLE;
					end
				end
				default: begin
					nxt_state = PFC_IDLE;
				end
			endcase
		end
	end

	// State, count and terminate registers.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= PFC_IDLE;
			count_ff <= '0;
			term_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			term_ff <= nxt_term;
		end
	end

	assign count_o = count_ff;
	assign expired_o = (state_ff == PFC_EXPIRED);
	assign terminate_o = term_ff;

endmodule : pfc_tenure_timer

`default_nettype wire

// ---- verification/pfc_host_model.sv ----
// Host bridge model that issues configuration cycles to the register slice.
`timescale 1ns/1ps
`default_nettype none

module pfc_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] rdata_i,
	output logic req_o,
	output logic we_o,
	output logic [7:0] addr_o,
	output logic [3:0] be_o,
	output logic [31:0] wdata_o
);
	////////////////////////////////////////
	// The bus starts idle so no access is seen before reset lets go.
	initial begin
		req_o = 1'b0;
		we_o = 1'b0;
		addr_o = 8'h00;
		be_o = 4'h0;
		wdata_o = 32'h0000_0000;
	end

	// One configuration cycle; the answer is read just after the taking edge.
	task automatic access(input logic we, input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] wdata, output logic [31:0] rdata, output logic ack);
		@(posedge clk_i);
		#1;
		req_o = 1'b1;
		we_o = we;
		addr_o = addr;
		be_o = be;
		wdata_o = wdata;
		@(posedge clk_i);
		#1;
		ack = ack_i;
		rdata = rdata_i;
		req_o = 1'b0;
		// Released lines go to their inverse so a stale value can never look valid.
		we_o = ~we;
		addr_o = ~addr;
		be_o = ~be;
		wdata_o = ~wdata;
	endtask : access
endmodule : pfc_host_model
`default_nettype wire

// ---- verification/pfc_config_regs_asserts.sv ----
// Checker of the configuration header register slice, bound to its top module.
`timescale 1ns/1ps
`default_nettype none

module pfc_config_regs_asserts (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic cfg_ack_o,
	input wire logic frame_start_i,
	input wire logic line_cmd_i,
	input wire logic [7:0] line_transfer_size_o,
	input wire logic line_cmd_ok_o,
	input wire logic [7:0] tenure_count_o,
	input wire logic tenure_expired_o,
	input wire logic terminate_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	////////////////////////////////////////
	// Decoded reads and line-size writes, so each property reads plainly.
	logic rd_hdr;
	logic rd_host;
	logic rd_ext;
	logic wr_line;
	logic [7:0] wline;
	assign rd_hdr = cfg_req_i && !cfg_we_i && cfg_addr_i[7:2] == 6'h03;
	assign rd_host = cfg_req_i && !cfg_we_i && cfg_addr_i[7:2] == 6'h04;
	assign rd_ext = cfg_req_i && !cfg_we_i && cfg_addr_i[7:2] == 6'h05;
	assign wr_line = cfg_req_i && cfg_we_i && cfg_addr_i[7:2] == 6'h03 && cfg_be_i[0];
	assign wline = cfg_wdata_i[7:0];

	////////////////////////////////////////
	// Handshake, fixed fields, line size, tenure count and termination.
	AST_ACK_NEXT: assert property (cfg_req_i |=> cfg_ack_o)
		else $error("no acknowledge after request");
	AST_ACK_ONLY: assert property (!cfg_req_i |=> !cfg_ack_o)
		else $error("acknowledge without request");
	AST_HDR_FIXED: assert property (rd_hdr |=> cfg_rdata_o[31:16] == 16'h0080)
		else $error("header byte pair wrong");
	AST_HOST_LOW: assert property (rd_host |=> cfg_rdata_o[10:0] == 11'h000)
		else $error("host window low bits not zero");
	AST_EXT_LOW: assert property (rd_ext |=> cfg_rdata_o[13:0] == 14'h0000)
		else $error("extension window low bits not zero");
	AST_LINE_OK: assert property (line_cmd_ok_o == (line_cmd_i && line_transfer_size_o != 8'h00))
		else $error("line command permit wrong");
	AST_LINE_WR: assert property (wr_line |=> line_transfer_size_o == $past(wline))
		else $error("line size not taken from write");
	AST_FRAME_ZERO: assert property (frame_start_i |=> tenure_count_o == 8'h00)
		else $error("tenure count not cleared at frame");
	AST_TERM_CAUSE: assert property (terminate_o |-> $past(tenure_expired_o))
		else $error("terminate without expiry");
	AST_TERM_ONE: assert property (terminate_o |=> !terminate_o && !tenure_expired_o)
		else $error("terminate not a single pulse");
endmodule : pfc_config_regs_asserts

bind pfc_config_regs pfc_config_regs_asserts u_chk (.clk_i, .arst_n_i, .cfg_req_i, .cfg_we_i,
	.cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .frame_start_i, .line_cmd_i,
	.line_transfer_size_o, .line_cmd_ok_o, .tenure_count_o, .tenure_expired_o, .terminate_o);
`default_nettype wire

// ---- verification/pfc_config_regs_tb.sv ----
// Self-checking testbench of the configuration header register slice.
`timescale 1ns/1ps
`default_nettype none

module pfc_config_regs_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic req, we, ack, fstart = 1'b0, done = 1'b0, gnt_n = 1'b0, lcmd = 1'b0, lok, expd, term;
	logic men = 1'b0, mreq = 1'b0, hhit, ehit, seen;
	logic [7:0] addr, lsize, cnt;
	logic [3:0] be;
	logic [31:0] wdata, rdata, maddr = 32'h0000_0000;
	int n_fail = 0;
	int tests_run = 0;

	////////////////////////////////////////
	// Clock at 25 MHz.
	always #20 clk = ~clk;

	pfc_host_model host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .req_o(req), .we_o(we),
		.addr_o(addr), .be_o(be), .wdata_o(wdata));
	pfc_config_regs dut (.clk_i(clk), .arst_n_i(arst_n), .cfg_req_i(req), .cfg_we_i(we),
		.cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
		.frame_start_i(fstart), .xfer_done_i(done), .gnt_n_i(gnt_n), .line_cmd_i(lcmd),
		.line_transfer_size_o(lsize), .line_cmd_ok_o(lok), .tenure_count_o(cnt),
		.tenure_expired_o(expd), .terminate_o(term), .mem_space_en_i(men), .mem_req_i(mreq),
		.mem_addr_i(maddr), .host_ctrl_hit_o(hhit), .ext_hit_o(ehit));

	////////////////////////////////////////
	// Shared compare, bus and timing helpers.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		logic [31:0] r;
		logic k;
		host.access(1'b1, a, b, d, r, k);
		chk({31'h0, k}, 32'h1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic k;
		host.access(1'b0, a, 4'hf, 32'h0, r, k);
		chk({31'h0, k}, 32'h1);
		chk(r, exp);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// Collects any terminate pulse over a span, since it stands one cycle only.
	task automatic watch(input int n);
		seen = 1'b0;
		repeat (n) begin
			cyc(1);
			seen = seen | term;
		end
	endtask : watch
	task automatic finish_test;
		if (n_fail == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// A hang is cut short at many times the expected run length.
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end

	////////////////////////////////////////
	// Main sequence: reset values, sizing, lane gating, tenure, decode, reset again.
	initial begin
		repeat (5) @(posedge clk);
		#1;
		arst_n = 1'b1;
		rd(8'h0c, 32'h0080_0000);
		rd(8'h10, 32'h0000_0000);
		rd(8'h14, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		lcmd = 1'b1;
		#1;
		chk({31'h0, lok}, 32'h0);
		wr(8'h0c, 4'hf, 32'hffff_ffff);
		rd(8'h0c, 32'h0080_ffff);
		wr(8'h0c, 4'h1, 32'h0000_0005);
		rd(8'h0c, 32'h0080_ff05);
		wr(8'h0c, 4'h3, 32'h0000_0210);
		rd(8'h0c, 32'h0080_0210);
		chk({24'h0, lsize}, 32'h10);
		chk({31'h0, lok}, 32'h1);
		wr(8'h10, 4'hf, 32'hffff_ffff);
		rd(8'h10, 32'hffff_f800);
		wr(8'h14, 4'hf, 32'hffff_ffff);
		rd(8'h14, 32'hffff_c000);
		wr(8'h14, 4'hf, 32'h2000_0000);
		rd(8'h14, 32'h2000_0000);
		fstart = 1'b1;
		cyc(1);
		fstart = 1'b0;
		watch(6);
		chk({31'h0, expd}, 32'h1);
		chk({24'h0, cnt}, 32'h2);
		chk({31'h0, seen}, 32'h0);
		gnt_n = 1'b1;
		watch(10);
		chk({31'h0, seen}, 32'h1);
		chk({31'h0, expd}, 32'h0);
		gnt_n = 1'b0;
		cyc(6);
		fstart = 1'b1;
		cyc(1);
		fstart = 1'b0;
		done = 1'b1;
		cyc(1);
		done = 1'b0;
		gnt_n = 1'b1;
		watch(10);
		chk({31'h0, seen}, 32'h0);
		gnt_n = 1'b0;
		cyc(6);
		wr(8'h0c, 4'h2, 32'h0000_0000);
		fstart = 1'b1;
		cyc(1);
		fstart = 1'b0;
		cyc(1);
		chk({31'h0, expd}, 32'h1);
		chk({24'h0, cnt}, 32'h0);
		gnt_n = 1'b1;
		watch(10);
		chk({31'h0, seen}, 32'h1);
		men = 1'b1;
		mreq = 1'b1;
		maddr = 32'hffff_f804;
		cyc(1);
		chk({30'h0, hhit, ehit}, 32'h2);
		maddr = 32'h2000_3ffc;
		cyc(1);
		chk({30'h0, hhit, ehit}, 32'h1);
		maddr = 32'h2000_4000;
		cyc(1);
		chk({30'h0, hhit, ehit}, 32'h0);
		maddr = 32'h2000_0000;
		men = 1'b0;
		cyc(1);
		chk({30'h0, hhit, ehit}, 32'h0);
		men = 1'b1;
		mreq = 1'b0;
		cyc(1);
		chk({30'h0, hhit, ehit}, 32'h0);
		wr(8'h10, 4'h8, 32'h1200_0000);
		rd(8'h10, 32'h12ff_f800);
		wr(8'h14, 4'h2, 32'h0000_ffff);
		rd(8'h14, 32'h2000_c000);
		arst_n = 1'b0;
		cyc(2);
		arst_n = 1'b1;
		rd(8'h0c, 32'h0080_0000);
		rd(8'h10, 32'h0000_0000);
		rd(8'h14, 32'h0000_0000);
		finish_test();
	end
endmodule : pfc_config_regs_tb
`default_nettype wire
